// >>> fscm_pkg.sv
// Constants and types for the fan spin-up and tach mode controller
package fscm_pkg;
   // Register offsets
   localparam logic [7:0] FSCM_ADDR_PWM_CFG  = 8'h4a;
   localparam logic [7:0] FSCM_ADDR_SPIN_CFG = 8'h4b;
   localparam logic [7:0] FSCM_ADDR_PWM_VAL  = 8'h4c;
   // Field positions in the PWM and tach configuration register
   localparam int FSCM_TACH_LSB    = 0;
   localparam int FSCM_MCLK_BIT    = 3;
   localparam int FSCM_POL_BIT     = 4;
   localparam int FSCM_PROG_BIT    = 5;
   // Reset values
   localparam logic [7:0] FSCM_PWM_CFG_RST  = 8'h20;
   localparam logic [7:0] FSCM_SPIN_CFG_RST = 8'h3f;
   localparam logic [5:0] FSCM_PWM_VAL_RST  = 6'h00;
   // Tach mode codes
   localparam logic [1:0] FSCM_TACH_PLAIN   = 2'h0;
   localparam logic [1:0] FSCM_TACH_KEEP    = 2'h1;
   localparam logic [1:0] FSCM_TACH_MODIFY  = 2'h2;
   localparam logic [1:0] FSCM_TACH_LEAST   = 2'h3;
   localparam logic [15:0] FSCM_TACH_NONE   = 16'hffff;
   // Spin-up duty codes and duty in 1/64 steps
   localparam logic [1:0] FSCM_SDUTY_SKIP   = 2'h0;
   localparam logic [1:0] FSCM_SDUTY_HALF   = 2'h1;
   localparam logic [1:0] FSCM_SDUTY_3Q     = 2'h2;
   localparam logic [6:0] FSCM_DUTY_HALF    = 7'h20;
   localparam logic [6:0] FSCM_DUTY_3Q      = 7'h30;
   localparam logic [6:0] FSCM_DUTY_FULL    = 7'h40;
   // Timing: clock rate, master clocks, base spin-up interval
   localparam longint FSCM_CLK_HZ      = 200000000;
   localparam longint FSCM_MCLK_FAST_HZ = 360000;
   localparam longint FSCM_MCLK_SLOW_HZ = 1400;
   localparam longint FSCM_SPIN_BASE_US = 50000;
   localparam longint FSCM_FAST_DIV_CYC = FSCM_CLK_HZ / FSCM_MCLK_FAST_HZ;
   localparam longint FSCM_SLOW_DIV_CYC = FSCM_CLK_HZ / FSCM_MCLK_SLOW_HZ;
   localparam longint FSCM_SPIN_BASE_CYC = FSCM_CLK_HZ / 1000000 * FSCM_SPIN_BASE_US;

   // Spin-up configuration register layout
   typedef struct packed {
      logic [1:0] unused;
      logic       fast_en_a;
      logic [1:0] fast_en_a_duty_sel;
      logic [2:0] fast_en_a_interval_sel;
   } fscm_spin_cfg_t;

   // Tach measurement status handed to the tach counter logic
   typedef struct packed {
      logic [1:0] mode_eff;
      logic       pulsed_en;
      logic       duty_mod_en;
   } fscm_tach_stat_t;
endpackage

// >>> fscm_pwm_gen.sv
// PWM waveform generator with open-drain pin drive
`timescale 1ns/1ps
`default_nettype none
module fscm_pwm_gen (
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       tick_in,
   input  wire logic [6:0] duty_in,
   input  wire logic       pol_in,
   output logic            pwm_on_out,
   output logic            pin_out,
   output logic            pin_oe_out
);
   logic [5:0] phase;

   // Period of 64 master clock ticks
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase <= 6'h00;
      end else if (tick_in) begin
         phase <= phase + 6'h01;
      end
   end

   // Fan is on while the phase is below the duty count
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pwm_on_out <= 1'b0;
      end else begin
         pwm_on_out <= ({1'b0, phase} < duty_in);
      end
   end

   // Open drain: polarity 0 pulls low for off, polarity 1 pulls low for on
   assign pin_out    = 1'b0;
   assign pin_oe_out = pol_in ? pwm_on_out : ~pwm_on_out;
endmodule
`default_nettype wire

// >>> fscm_ctrl.sv
// Fan spin-up sequencer and tach mode control with register file
`timescale 1ns/1ps
`default_nettype none
module fscm_ctrl #(
   parameter int SLOW_DIV_CYC = int'(fscm_pkg::FSCM_SLOW_DIV_CYC),
   parameter int SPIN_BASE_CYC = int'(fscm_pkg::FSCM_SPIN_BASE_CYC)
) (
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     reg_wr_in,
   input  wire logic [7:0]               reg_addr_in,
   input  wire logic [7:0]               reg_wdata_in,
   output logic [7:0]                    reg_rdata_out,
   input  wire logic [5:0]               lut_pwm_in,
   input  wire logic [15:0]              tach_count_in,
   input  wire logic                     tach_below_min_in,
   input  wire logic [15:0]              tach_setpoint_in,
   output logic [15:0]                   tach_reading_out,
   output logic                          tach_err_out,
   output fscm_pkg::fscm_tach_stat_t     tach_stat_out,
   output logic                          fast_en_a_active_out,
   output logic                          pwm_on_out,
   output logic                          pwm_pin_out,
   output logic                          pwm_pin_oe_out
);
   import fscm_pkg::*;

   typedef enum logic {FSCM_IDLE, FSCM_SPIN} fscm_state_t;

   localparam logic [23:0] FAST_DIV = 24'(FSCM_FAST_DIV_CYC);
   localparam logic [23:0] SLOW_DIV = 24'(SLOW_DIV_CYC);
   localparam logic [23:0] BASE_DIV = 24'(SPIN_BASE_CYC);

   // Number of base intervals for an interval code, doubling per step
   function automatic logic [6:0] intv_ticks(input logic [2:0] code);
      intv_ticks = 7'h01 << (code - 3'h1);
   endfunction

   logic [1:0]      tach_mode_sel;
   logic            pwm_master_clk_sel;
   logic            pwm_pol;
   logic            pwm_prog;
   fscm_spin_cfg_t  spin_cfg;
   logic [5:0]      pwm_duty_value;
   logic [5:0]      drive_val;
   logic [5:0]      prev_drive;
   fscm_state_t     state;
   fscm_state_t     next_state;
   logic [23:0]     mclk_cnt;
   logic            mclk_tick;
   logic [23:0]     base_cnt;
   logic [6:0]      base_ticks;
   logic            start_req;
   logic            spin_skip;
   logic            tach_reached;
   logic            intv_done;
   logic [6:0]      duty;
   logic [6:0]      spin_duty;

   // Register writes; reserved bits are not stored
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tach_mode_sel      <= FSCM_PWM_CFG_RST[FSCM_TACH_LSB +: 2];
         pwm_master_clk_sel <= FSCM_PWM_CFG_RST[FSCM_MCLK_BIT];
         pwm_pol            <= FSCM_PWM_CFG_RST[FSCM_POL_BIT];
         pwm_prog           <= FSCM_PWM_CFG_RST[FSCM_PROG_BIT];
         spin_cfg           <= FSCM_SPIN_CFG_RST;
      end else if (reg_wr_in) begin
         if (reg_addr_in == FSCM_ADDR_PWM_CFG) begin
            tach_mode_sel      <= reg_wdata_in[FSCM_TACH_LSB +: 2];
            pwm_master_clk_sel <= reg_wdata_in[FSCM_MCLK_BIT];
            pwm_pol            <= reg_wdata_in[FSCM_POL_BIT];
            pwm_prog           <= reg_wdata_in[FSCM_PROG_BIT];
         end else if (reg_addr_in == FSCM_ADDR_SPIN_CFG) begin
            spin_cfg <= {2'h0, reg_wdata_in[5:0]};
         end
      end
   end

   // PWM value: written when programming is on, else follows the lookup table
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pwm_duty_value <= FSCM_PWM_VAL_RST;
      end else if (!pwm_prog) begin
         pwm_duty_value <= lut_pwm_in;
      end else if (reg_wr_in && reg_addr_in == FSCM_ADDR_PWM_VAL) begin
         pwm_duty_value <= reg_wdata_in[5:0];
      end
   end

   // Read data register
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_addr_in == FSCM_ADDR_PWM_CFG) begin
         reg_rdata_out <= {2'h0, pwm_prog, pwm_pol, pwm_master_clk_sel, 1'b0, tach_mode_sel};
      end else if (reg_addr_in == FSCM_ADDR_SPIN_CFG) begin
         reg_rdata_out <= {2'h0, spin_cfg[5:0]};
      end else if (reg_addr_in == FSCM_ADDR_PWM_VAL) begin
         reg_rdata_out <= (state == FSCM_SPIN) ? 8'h00 : {2'h0, pwm_duty_value};
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end

   always_comb begin
      tach_stat_out.mode_eff    = pwm_master_clk_sel ? tach_mode_sel : FSCM_TACH_PLAIN;
      tach_stat_out.pulsed_en   = (tach_stat_out.mode_eff != FSCM_TACH_PLAIN);
      tach_stat_out.duty_mod_en = (tach_stat_out.mode_eff == FSCM_TACH_MODIFY);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tach_reading_out <= FSCM_TACH_NONE;
         tach_err_out     <= 1'b0;
      end else begin
         if (tach_stat_out.pulsed_en && tach_below_min_in) begin
            tach_reading_out <= FSCM_TACH_NONE;
         end else begin
            tach_reading_out <= tach_count_in;
         end
         tach_err_out <= (tach_reading_out > tach_setpoint_in);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mclk_cnt <= 24'h000000;
      end else if (mclk_tick) begin
         mclk_cnt <= 24'h000000;
      end else begin
         mclk_cnt <= mclk_cnt + 24'h000001;
      end
   end
   // Compare with >= so a switch to the short period cannot leave the count above the limit
   assign mclk_tick = (mclk_cnt >= (pwm_master_clk_sel ? SLOW_DIV : FAST_DIV) - 24'h000001);

   assign drive_val    = pwm_duty_value;
   assign start_req    = (prev_drive == 6'h00) && (drive_val != 6'h00);
   assign spin_skip    = (spin_cfg.fast_en_a_interval_sel == 3'h0) ||
                         (spin_cfg.fast_en_a_duty_sel == FSCM_SDUTY_SKIP && !spin_cfg.fast_en_a);
   assign tach_reached = !tach_below_min_in && (tach_reading_out <= tach_setpoint_in);
   assign intv_done    = (base_cnt == BASE_DIV - 24'h000001) &&
                         (base_ticks >= intv_ticks(spin_cfg.fast_en_a_interval_sel) - 7'h01);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         prev_drive <= 6'h00;
      end else begin
         prev_drive <= drive_val;
      end
   end

   // Spin-up state
   always_comb begin
      next_state = state;
      case (state)
         FSCM_IDLE: begin
            if (start_req && !spin_skip) begin
               next_state = FSCM_SPIN;
            end
         end
         FSCM_SPIN: begin
            if (intv_done || (spin_cfg.fast_en_a && tach_reached) || spin_skip) begin
               next_state = FSCM_IDLE;
            end
         end
         default: next_state = FSCM_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= FSCM_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Interval timer in base steps
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         base_cnt   <= 24'h000000;
         base_ticks <= 7'h00;
      end else if (state != FSCM_SPIN) begin
         base_cnt   <= 24'h000000;
         base_ticks <= 7'h00;
      end else if (base_cnt == BASE_DIV - 24'h000001) begin
         base_cnt   <= 24'h000000;
         base_ticks <= base_ticks + 7'h01;
      end else begin
         base_cnt <= base_cnt + 24'h000001;
      end
   end

   always_comb begin
      if (spin_cfg.fast_en_a) begin
         spin_duty = FSCM_DUTY_FULL;
      end else if (spin_cfg.fast_en_a_duty_sel == FSCM_SDUTY_HALF) begin
         spin_duty = FSCM_DUTY_HALF;
      end else if (spin_cfg.fast_en_a_duty_sel == FSCM_SDUTY_3Q) begin
         spin_duty = FSCM_DUTY_3Q;
      end else begin
         spin_duty = FSCM_DUTY_FULL;
      end
   end
   assign duty = (state == FSCM_SPIN) ? spin_duty : {1'b0, drive_val};
   assign fast_en_a_active_out = (state == FSCM_SPIN);

   fscm_pwm_gen u_pwm (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .tick_in    (mclk_tick),
      .duty_in    (duty),
      .pol_in     (pwm_pol),
      .pwm_on_out (pwm_on_out),
      .pin_out    (pwm_pin_out),
      .pin_oe_out (pwm_pin_oe_out)
   );

   eff_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !pwm_master_clk_sel |-> tach_stat_out.mode_eff == FSCM_TACH_PLAIN && !tach_stat_out.pulsed_en)
      else $error("fast master clock must force plain tach mode");
   mode_map_a: assert property (@(posedge clk_in) disable iff (rst_in)
      pwm_master_clk_sel && tach_mode_sel == FSCM_TACH_MODIFY |-> tach_stat_out.duty_mod_en)
      else $error("mode 10 must allow duty modification");
   reading_sat_a: assert property (@(posedge clk_in) disable iff (rst_in)
      tach_stat_out.pulsed_en && tach_below_min_in |=> tach_reading_out == FSCM_TACH_NONE)
      else $error("pulsed tach below minimum must read all ones");
   rsvd_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
      reg_addr_in == FSCM_ADDR_SPIN_CFG |=> reg_rdata_out[7:6] == 2'h0)
      else $error("spin-up config upper bits must read zero");
   val_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state == FSCM_SPIN && reg_addr_in == FSCM_ADDR_PWM_VAL |=> reg_rdata_out == 8'h00)
      else $error("pwm value must read zero during spin-up");
   fast_full_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state == FSCM_SPIN && spin_cfg.fast_en_a |-> duty == FSCM_DUTY_FULL)
      else $error("fast spin-up must drive full duty");
   half_duty_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state == FSCM_SPIN && !spin_cfg.fast_en_a && spin_cfg.fast_en_a_duty_sel == FSCM_SDUTY_HALF
      |-> duty == FSCM_DUTY_HALF)
      else $error("duty code 01 must give half duty");
   skip_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state == FSCM_IDLE && spin_cfg.fast_en_a_interval_sel == 3'h0 |=> state == FSCM_IDLE)
      else $error("interval 000 must bypass spin-up");
   spin_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state == FSCM_IDLE && start_req && !spin_skip |=> state == FSCM_SPIN)
      else $error("spin-up must start on zero to nonzero drive");
   tach_end_a: assert property (@(posedge clk_in) disable iff (rst_in)
      state == FSCM_SPIN && spin_cfg.fast_en_a && tach_reached |=> state == FSCM_IDLE)
      else $error("fast spin-up must end when tach reaches setpoint");
endmodule
`default_nettype wire

// >>> fscm_fan_model.sv
// Behavioural cooling fan: PWM power input, tach count output
`timescale 1ns/1ps
`default_nettype none
module fscm_fan_model #(
   parameter logic [15:0] RATE     = 16'h0100,
   parameter logic [15:0] STOP_CNT = 16'hfff0,
   parameter logic [15:0] TOP_CNT  = 16'h0400,
   parameter logic [15:0] MIN_CNT  = 16'hf000
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        power_in,
   output logic [15:0]      tach_count_out,
   output logic             below_min_out
);
   // Speeds up while powered, coasts down otherwise; count falls as speed rises
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tach_count_out <= STOP_CNT;
      end else if (power_in) begin
         tach_count_out <= (tach_count_out < TOP_CNT + RATE) ? TOP_CNT : tach_count_out - RATE;
      end else begin
         tach_count_out <= (tach_count_out > STOP_CNT - RATE) ? STOP_CNT : tach_count_out + RATE;
      end
   end
   // Too slow for a trustworthy tach count
   assign below_min_out = tach_count_out > MIN_CNT;
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the fan spin-up and tach mode controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import fscm_pkg::*;
   localparam int   SLOW = 8;
   localparam int   BASE = 20;
   logic            clk_in = 1'b0;
   logic            rst_in = 1'b1;
   logic            wr = 1'b0;
   logic [7:0]      addr = 8'h00;
   logic [7:0]      wdata = 8'h00;
   logic [15:0]     setpoint = 16'hffff;
   logic [5:0]      lut = 6'h00;
   logic [7:0]      rdata;
   logic [15:0]     count;
   logic [15:0]     reading;
   logic            below_min;
   logic            err;
   logic            spin;
   logic            pwm_on;
   logic            pin;
   logic            pin_oe;
   fscm_tach_stat_t stat;
   logic [3:0]      e;
   int              n_fail = 0;
   int              checks = 0;

   fscm_ctrl #(.SLOW_DIV_CYC(SLOW), .SPIN_BASE_CYC(BASE)) fscm_ctrl_i (
      .clk_in(clk_in), .rst_in(rst_in), .reg_wr_in(wr), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .lut_pwm_in(lut),
      .tach_count_in(count), .tach_below_min_in(below_min), .tach_setpoint_in(setpoint),
      .tach_reading_out(reading), .tach_err_out(err), .tach_stat_out(stat),
      .fast_en_a_active_out(spin), .pwm_on_out(pwm_on), .pwm_pin_out(pin), .pwm_pin_oe_out(pin_oe));
   // Open-drain line with pull-up feeds the fan
   fscm_fan_model fscm_fan_model_i (
      .clk_in(clk_in), .rst_in(rst_in), .power_in(pin_oe ? pin : 1'b1),
      .tach_count_out(count), .below_min_out(below_min));

   // Free-running clock
   always #2.5 clk_in = ~clk_in;

   task automatic summarize();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      checks++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk_in);
      wr = 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      addr = a;
      @(negedge clk_in);
      chk({8'h00, rdata}, {8'h00, exp});
   endtask

   // Start a spin-up from zero drive, time it, measure duty over one period
   task automatic run_spin(input logic [7:0] cfg, input int lo, input int hi, input int duty8);
      int n;
      int hi_cnt;
      n = 0;
      hi_cnt = 0;
      wr_reg(FSCM_ADDR_SPIN_CFG, cfg);
      wr_reg(FSCM_ADDR_PWM_VAL, 8'h00);
      repeat (300) @(negedge clk_in);
      wr_reg(FSCM_ADDR_PWM_VAL, 8'h05);
      for (int k = 0; k < 1500; k++) begin
         @(negedge clk_in);
         if (spin === 1'b1) begin
            n++;
            if (n >= 513 && n <= 1024 && pwm_on === 1'b1) hi_cnt++;
            if (n == 4) chk({8'h00, rdata}, 16'h0000);
         end else if (n > 0) begin
            break;
         end
      end
      chk_rng(n, lo, hi);
      if (duty8 >= 0) chk_rng(hi_cnt, duty8 - 8, duty8 + 8);
      repeat (2) @(negedge clk_in);
      chk({8'h00, rdata}, 16'h0005);
   endtask

   // Main test sequence
   initial begin
      repeat (8) @(negedge clk_in);
      rst_in = 1'b0;
      rd_chk(FSCM_ADDR_PWM_CFG, 8'h20);
      rd_chk(FSCM_ADDR_SPIN_CFG, 8'h3f);
      rd_chk(FSCM_ADDR_PWM_VAL, 8'h00);
      rd_chk(8'h4e, 8'h00);
      wr_reg(FSCM_ADDR_SPIN_CFG, 8'hff);
      rd_chk(FSCM_ADDR_SPIN_CFG, 8'h3f);
      // Every tach mode under both master clocks, fan stopped
      for (int c = 0; c < 8; c++) begin
         wr_reg(FSCM_ADDR_PWM_CFG, {4'h2, c[2], 1'b0, c[1:0]});
         repeat (2) @(negedge clk_in);
         e = {c[2] ? c[1:0] : 2'h0, c[2] && c[1:0] != 2'h0, c[2] && c[1:0] == 2'h2};
         chk({12'h000, stat}, {12'h000, e});
         chk(reading, e[1] ? FSCM_TACH_NONE : count);
         if (c == 5) begin
            setpoint = 16'h1000;
            repeat (3) @(negedge clk_in);
            chk({15'h0000, err}, 16'h0001);
         end
      end
      setpoint = 16'h0000;
      for (int i = 1; i < 8; i++) begin
         run_spin({5'h01, 3'(i)}, (BASE << (i - 1)) - 1, (BASE << (i - 1)) + 2, (i == 7) ? 256 : -1);
      end
      run_spin(8'h17, 1279, 1282, 384);
      run_spin(8'h1f, 1279, 1282, 512);
      run_spin(8'h2f, 1279, 1282, 512);
      run_spin(8'h28, 0, 0, -1);
      run_spin(8'h07, 0, 0, -1);
      run_spin(8'h27, 1279, 1282, 512);
      // Fast spin-up ends early once the tach reading reaches the setpoint
      setpoint = 16'h2000;
      run_spin(8'h2f, 150, 400, -1);
      // Polarity 0 pulls the pin low for fan off, polarity 1 for fan on; pin data stays low
      chk({14'h0000, pin, pin_oe}, {14'h0000, 1'b0, ~pwm_on});
      wr_reg(FSCM_ADDR_PWM_CFG, 8'h3b);
      repeat (2) @(negedge clk_in);
      chk({14'h0000, pin, pin_oe}, {14'h0000, 1'b0, pwm_on});
      // Programming off: the value follows the lookup input and ignores writes
      lut = 6'h2a;
      wr_reg(FSCM_ADDR_PWM_CFG, 8'h0b);
      wr_reg(FSCM_ADDR_PWM_VAL, 8'h11);
      rd_chk(FSCM_ADDR_PWM_VAL, 8'h2a);
      summarize();
   end

   // Watchdog against a hung run
   initial begin
      #(60000 * 5);
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
